// File: gld_cfg.svh
// addresses, field values and timing figures of the gauge display block
`ifndef GLD_CFG_SVH
`define GLD_CFG_SVH
`define GLD_ADDR_COMP_HI    8'h0D
`define GLD_ADDR_COMP_LO    8'h0E
`define GLD_ADDR_ENERGY_HI  8'h0F
`define GLD_ADDR_ENERGY_LO  8'h10
`define GLD_ADDR_SOFT_RST   8'h39
`define GLD_RST_ARMED       8'h00
`define GLD_RST_FIRE        8'h80
`define GLD_READ_NONE       8'h00
`define GLD_PIN_SYNC_IDLE   4'h6
`define GLD_CPI_CI_LEVEL    8'h40
`define GLD_CPI_MAX         8'hFF
`define GLD_CPI_RESET       8'h00
`define GLD_CHARGE_RESET    16'h0000
`define GLD_CHARGE_MAX      16'hFFFF
`define GLD_SEG_COUNT       5
`define GLD_CLK_HZ          20000000
`define GLD_DISPLAY_CONTROL_INPUT_WINDOW_MS  4000
`define GLD_MUX_HZ          100
`define GLD_MUX_DUTY_PCT    30
`define GLD_BLINK_HZ        4
`endif

// File: gld_core.sv
// gauge result registers, software reset and led capacity display control
`timescale 1ns/1ps
`include "gld_cfg.svh"
// Overview of operation
// - compensated charge readable as high and low bytes at 0Dh and 0Eh.
// - nominal counter and full reference never see rate or temperature correction.
// - scaled energy readable as high and low bytes at 0Fh and 10h.
// - writing 80h over 00h in the reset register fires a gauge reset.
// - reset loads full reference, clears counters, sets inaccurate and replaced flags.
// - self-discharge steps ignored while program input five is high.
// - each lit segment stands for one fifth of the full reference.
// - segment count from compensated charge; nominal counter untouched.
// - display pin high keeps all segments dark.
// - display pin floating shows segments while a valid charge is seen.
// - display pin pulled low shows segments for four seconds.
// - segments 1,3,5 and 2,4 form two alternating banks.
// - banks modulated near 100 Hz, each on thirty percent.
// - first empty warning blinks segment one at four hertz.
// - final empty warning blanks the display whatever the pin.
// - inaccurate flag sets at count 64; reference update clears both.
module gld_core #(
  parameter int unsigned WINDOW_CYC     = `GLD_DISPLAY_CONTROL_INPUT_WINDOW_MS * (`GLD_CLK_HZ / 1000),
  parameter int unsigned MUX_PERIOD_CYC = `GLD_CLK_HZ / `GLD_MUX_HZ,
  parameter int unsigned MUX_ON_CYC     = MUX_PERIOD_CYC * `GLD_MUX_DUTY_PCT / 100,
  parameter int unsigned BLINK_HALF_CYC = `GLD_CLK_HZ / (2 * `GLD_BLINK_HZ)
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regWriteData,
  output logic      [7:0]  regReadData,
  output logic             regReadValid,
  // gauge arithmetic results
  input  wire logic [15:0] compChargeIn,
  input  wire logic [15:0] scaledEnergyIn,
  input  wire logic [15:0] programmedFullCount,
  // gauge events
  input  wire logic        chargeStep,
  input  wire logic        dischargeStep,
  input  wire logic        selfDischargeStep,
  input  wire logic        validChargeEvent,
  input  wire logic        fullRefUpdate,
  input  wire logic [15:0] fullRefValue,
  input  wire logic        validDischargeSet,
  input  wire logic        batteryReplacedClear,
  input  wire logic        firstEmptyWarningFlag,
  input  wire logic        finalEmptyWarningFlag,
  // pins
  input  wire logic        programInputFive,
  input  wire logic        displayPullUpSense,
  input  wire logic        displayPullDownSense,
  input  wire logic        validChargeDetect,
  // gauge state
  output logic [15:0]      nominalChargeCounter,
  output logic [15:0]      measuredFullReference,
  output logic [7:0]       inaccurateChargeCounter,
  output logic             capacityInaccurateFlag,
  output logic             batteryReplacedFlag,
  output logic             validDischargeField,
  output logic             gaugeReset,
  // led drive
  output logic [4:0]       segmentOutputs_n,
  output logic             ledCommonDrive
);
  localparam int unsigned TW = $clog2(WINDOW_CYC + 1);
  localparam logic [TW-1:0] WINDOW_C = TW'(WINDOW_CYC);

  gld_led_if ledBus ();

  logic [3:0]                  pinMeta_reg;
  logic [3:0]                  pinSync_reg;
  logic [15:0]                 compCharge_reg;
  logic [15:0]                 scaledEnergy_reg;
  logic [7:0]                  softReset_reg;
  gld_pkg::gld_display_control_input_mode_type  dispMode_reg;
  gld_pkg::gld_display_control_input_mode_type  dispModePrev_reg;
  gld_pkg::gld_display_control_input_state_type dispState_reg;
  gld_pkg::gld_display_control_input_state_type dispState_next;
  logic [TW-1:0]               window_reg;
  logic                        timedStart;
  logic                        chargeShow;
  logic                        progFive;
  logic [18:0]                 compScaled;
  logic [4:0]                  litNext;

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
    hits = (addr == target);
  endfunction : hits

  function automatic gld_pkg::gld_display_control_input_mode_type resolveDisp(input logic up,
                                                             input logic down);
    if (up && down) begin
      resolveDisp = gld_pkg::DISPLAY_CONTROL_INPUT_HIGH;
    end else if (!up && !down) begin
      resolveDisp = gld_pkg::DISPLAY_CONTROL_INPUT_LOW;
    end else begin
      resolveDisp = gld_pkg::DISPLAY_CONTROL_INPUT_FLOAT;
    end
  endfunction : resolveDisp

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: five, pull-up sense, pull-down sense, charge detect
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // display senses idle high so leaving reset is no entry into low
      pinMeta_reg <= `GLD_PIN_SYNC_IDLE;
      pinSync_reg <= `GLD_PIN_SYNC_IDLE;
    end else begin
      pinMeta_reg <= {validChargeDetect, displayPullDownSense, displayPullUpSense,
                      programInputFive};
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign progFive = pinSync_reg[0];

  //////////////////////////////////////////////////////////////////////////////
  // compensated result capture
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      compCharge_reg   <= `GLD_CHARGE_RESET;
      scaledEnergy_reg <= `GLD_CHARGE_RESET;
    end else begin
      compCharge_reg   <= compChargeIn;
      scaledEnergy_reg <= scaledEnergyIn;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      softReset_reg <= `GLD_RST_ARMED;
      gaugeReset    <= 1'b0;
    end else begin
      gaugeReset <= regWrite && hits(regAddr, `GLD_ADDR_SOFT_RST)
                    && (softReset_reg == `GLD_RST_ARMED) && (regWriteData == `GLD_RST_FIRE);
      if (regWrite && hits(regAddr, `GLD_ADDR_SOFT_RST)) begin
        softReset_reg <= regWriteData;
      end
    end
  end

  // byte reads of results; reset register reads as zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      regReadData  <= `GLD_READ_NONE;
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
      if (!regRead) begin
        regReadData <= regReadData;
      end else if (hits(regAddr, `GLD_ADDR_COMP_HI)) begin
        regReadData <= compCharge_reg[15:8];
      end else if (hits(regAddr, `GLD_ADDR_COMP_LO)) begin
        regReadData <= compCharge_reg[7:0];
      end else if (hits(regAddr, `GLD_ADDR_ENERGY_HI)) begin
        regReadData <= scaledEnergy_reg[15:8];
      end else if (hits(regAddr, `GLD_ADDR_ENERGY_LO)) begin
        regReadData <= scaledEnergy_reg[7:0];
      end else begin
        regReadData <= `GLD_READ_NONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // nominal counter uses raw steps only
  always_ff @(posedge clock) begin
    if (!reset_n || gaugeReset) begin
      nominalChargeCounter <= `GLD_CHARGE_RESET;
    end else if (chargeStep) begin
      if (nominalChargeCounter != `GLD_CHARGE_MAX) begin
        nominalChargeCounter <= nominalChargeCounter + 16'h0001;
      end
    end else if (dischargeStep) begin
      if (nominalChargeCounter != `GLD_CHARGE_RESET) begin
        nominalChargeCounter <= nominalChargeCounter - 16'h0001;
      end
    end else if (selfDischargeStep && !progFive) begin
      if (nominalChargeCounter != `GLD_CHARGE_RESET) begin
        nominalChargeCounter <= nominalChargeCounter - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || gaugeReset) begin
      measuredFullReference <= programmedFullCount;
    end else if (fullRefUpdate) begin
      measuredFullReference <= fullRefValue;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || gaugeReset) begin
      inaccurateChargeCounter <= `GLD_CPI_RESET;
      capacityInaccurateFlag  <= 1'b1;
    end else if (fullRefUpdate) begin
      inaccurateChargeCounter <= `GLD_CPI_RESET;
      capacityInaccurateFlag  <= 1'b0;
    end else if (validChargeEvent && inaccurateChargeCounter != `GLD_CPI_MAX) begin
      inaccurateChargeCounter <= inaccurateChargeCounter + 8'h01;
      if (inaccurateChargeCounter + 8'h01 == `GLD_CPI_CI_LEVEL) begin
        capacityInaccurateFlag <= 1'b1;
      end
    end
  end

  // replaced flag set, discharge field cleared
  always_ff @(posedge clock) begin
    if (!reset_n || gaugeReset) begin
      batteryReplacedFlag <= 1'b1;
      validDischargeField <= 1'b0;
    end else begin
      batteryReplacedFlag <= batteryReplacedFlag && !batteryReplacedClear;
      validDischargeField <= validDischargeField || validDischargeSet;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // compensated charge scaled by segment count
  assign compScaled = 19'(compCharge_reg) * 19'(`GLD_SEG_COUNT);

  // segment k lit above k fifths of the reference
  for (genvar k = 0; k < `GLD_SEG_COUNT; k++) begin : g_lit
    assign litNext[k] = (compScaled > 19'(measuredFullReference) * 19'(k))
                        && (compCharge_reg != `GLD_CHARGE_RESET);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dispMode_reg     <= gld_pkg::DISPLAY_CONTROL_INPUT_HIGH;
      dispModePrev_reg <= gld_pkg::DISPLAY_CONTROL_INPUT_HIGH;
    end else begin
      dispMode_reg     <= resolveDisp(pinSync_reg[1], pinSync_reg[2]);
      dispModePrev_reg <= dispMode_reg;
    end
  end

  assign timedStart = (dispMode_reg == gld_pkg::DISPLAY_CONTROL_INPUT_LOW)
                      && (dispModePrev_reg != gld_pkg::DISPLAY_CONTROL_INPUT_LOW);
  assign chargeShow = (dispMode_reg == gld_pkg::DISPLAY_CONTROL_INPUT_FLOAT) && pinSync_reg[3];

  always_comb begin
    dispState_next = dispState_reg;
    case (dispState_reg)
      gld_pkg::ST_DARK: begin
        if (timedStart) begin
          dispState_next = gld_pkg::ST_TIMED;
        end else if (chargeShow) begin
          dispState_next = gld_pkg::ST_CHARGE;
        end
      end
      gld_pkg::ST_CHARGE: begin
        if (timedStart) begin
          dispState_next = gld_pkg::ST_TIMED;
        end else if (!chargeShow) begin
          dispState_next = gld_pkg::ST_DARK;
        end
      end
      gld_pkg::ST_TIMED: begin
        if (dispMode_reg == gld_pkg::DISPLAY_CONTROL_INPUT_HIGH || window_reg == TW'(1)) begin
          dispState_next = gld_pkg::ST_DARK;
        end
      end
      default: begin
        dispState_next = gld_pkg::ST_DARK;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dispState_reg <= gld_pkg::ST_DARK;
    end else begin
      dispState_reg <= dispState_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      window_reg <= '0;
    end else if (timedStart) begin
      window_reg <= WINDOW_C;
    end else if (window_reg != '0) begin
      window_reg <= window_reg - TW'(1);
    end
  end

  // high pin blanks; final warning blanks
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ledBus.enable  <= 1'b0;
      ledBus.pattern <= 5'h00;
      ledBus.blink   <= 1'b0;
    end else begin
      ledBus.enable  <= (dispState_next != gld_pkg::ST_DARK)
                        && (dispMode_reg != gld_pkg::DISPLAY_CONTROL_INPUT_HIGH) && !finalEmptyWarningFlag;
      ledBus.pattern <= litNext;
      ledBus.blink   <= firstEmptyWarningFlag;
    end
  end

  gld_led_mux #(
    .PERIOD_CYC     (MUX_PERIOD_CYC),
    .ON_CYC         (MUX_ON_CYC),
    .BLINK_HALF_CYC (BLINK_HALF_CYC)
  ) u_mux (
    .clock   (clock),
    .reset_n (reset_n),
    .ledBus  (ledBus.mux)
  );

  assign segmentOutputs_n = ledBus.segOn_n;
  assign ledCommonDrive   = ledBus.commonOn;

  //////////////////////////////////////////////////////////////////////////////
  property p_soft_fire;
    @(posedge clock) disable iff (!reset_n)
    regWrite && hits(regAddr, `GLD_ADDR_SOFT_RST) && softReset_reg == `GLD_RST_ARMED
      && regWriteData == `GLD_RST_FIRE |=> gaugeReset ##1 nominalChargeCounter == 16'h0000;
  endproperty
  a_soft_fire: assert property (p_soft_fire)
    else $error("soft reset did not fire");

  property p_reset_load;
    @(posedge clock) disable iff (!reset_n)
    gaugeReset |=> capacityInaccurateFlag && batteryReplacedFlag && !validDischargeField
      && inaccurateChargeCounter == 8'h00 && measuredFullReference == $past(programmedFullCount);
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("gauge reset left state wrong");

  property p_self_hold;
    @(posedge clock) disable iff (!reset_n)
    progFive && selfDischargeStep && !chargeStep && !dischargeStep && !gaugeReset
      |=> $stable(nominalChargeCounter);
  endproperty
  a_self_hold: assert property (p_self_hold)
    else $error("self-discharge stepped while held off");

  property p_pin_high;
    @(posedge clock) disable iff (!reset_n)
    dispMode_reg == gld_pkg::DISPLAY_CONTROL_INPUT_HIGH |=> !ledBus.enable ##1 ledBus.segOn_n == 5'h1F;
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("segments lit with display pin high");

  property p_final_blank;
    @(posedge clock) disable iff (!reset_n)
    finalEmptyWarningFlag |=> !ledBus.enable;
  endproperty
  a_final_blank: assert property (p_final_blank)
    else $error("display on during final empty warning");

  property p_ci_level;
    @(posedge clock) disable iff (!reset_n)
    validChargeEvent && !fullRefUpdate && !gaugeReset && inaccurateChargeCounter == 8'h3F
      |=> capacityInaccurateFlag && inaccurateChargeCounter == 8'h40;
  endproperty
  a_ci_level: assert property (p_ci_level)
    else $error("inaccurate flag missed count 64");

  property p_window_start;
    @(posedge clock) disable iff (!reset_n)
    timedStart && !finalEmptyWarningFlag |=> window_reg == WINDOW_C
      && dispState_reg == gld_pkg::ST_TIMED && ledBus.enable;
  endproperty
  a_window_start: assert property (p_window_start)
    else $error("timed window did not start");

endmodule : gld_core

// File: gld_core_tb.sv
// self-checking bench of the gauge display block
`timescale 1ns/1ps
module gld_core_tb;
  logic clock = 1'b0, reset_n = 1'b0, clr = 1'b1;
  logic regWrite = 1'b0, regRead = 1'b0, chargeStep = 1'b0, dischargeStep = 1'b0;
  logic selfDischargeStep = 1'b0, validChargeEvent = 1'b0, fullRefUpdate = 1'b0;
  logic validDischargeSet = 1'b0, batteryReplacedClear = 1'b0, programInputFive = 1'b0;
  logic firstEmptyWarningFlag = 1'b0, finalEmptyWarningFlag = 1'b0, validChargeDetect = 1'b0;
  logic displayPullUpSense = 1'b1, displayPullDownSense = 1'b1;
  logic [7:0]  regAddr = 8'h00, regWriteData = 8'h00, regReadData, inaccurateChargeCounter, d;
  logic [15:0] compChargeIn = 16'h0000, scaledEnergyIn = 16'h0000, fullRefValue = 16'h0000;
  logic [15:0] programmedFullCount = 16'h1000, nominalChargeCounter, measuredFullReference;
  logic        regReadValid, capacityInaccurateFlag, batteryReplacedFlag, validDischargeField;
  logic        gaugeReset, ledCommonDrive, mixErr;
  logic [4:0]  segmentOutputs_n, litMask;
  logic [15:0] flags, cases [5];
  int          onCount, seg1Count, pulses = 0, bad_count = 0, compares = 0, seed = 85;

  assign flags = {5'h00, capacityInaccurateFlag, batteryReplacedFlag, validDischargeField,
                  inaccurateChargeCounter};

  gld_core #(.WINDOW_CYC(200), .MUX_PERIOD_CYC(20), .MUX_ON_CYC(6), .BLINK_HALF_CYC(50)) dut_u (
    .clock, .reset_n, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData, .regReadValid,
    .compChargeIn, .scaledEnergyIn, .programmedFullCount, .chargeStep, .dischargeStep,
    .selfDischargeStep, .validChargeEvent, .fullRefUpdate, .fullRefValue, .validDischargeSet,
    .batteryReplacedClear, .firstEmptyWarningFlag, .finalEmptyWarningFlag, .programInputFive,
    .displayPullUpSense, .displayPullDownSense, .validChargeDetect, .nominalChargeCounter,
    .measuredFullReference, .inaccurateChargeCounter, .capacityInaccurateFlag,
    .batteryReplacedFlag, .validDischargeField, .gaugeReset, .segmentOutputs_n, .ledCommonDrive);

  gld_led_model led_u (.clock, .segments_n(segmentOutputs_n), .common(ledCommonDrive),
    .clear(clr), .litMask, .onCount, .seg1Count, .mixErr);

  initial begin
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    if (gaugeReset === 1'b1) pulses++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    regAddr = a;
    regRead = 1'b1;
    cyc(1);
    chk("readValid", 16'h0001, {15'h0000, regReadValid});
    q = regReadData;
    regRead = 1'b0;
    cyc(1);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regAddr = a;
    regWriteData = v;
    regWrite = 1'b1;
    cyc(1);
    regWrite = 1'b0;
    cyc(3);
  endtask : wr

  task automatic resetChk();
    chk("nominal", 16'h0000, nominalChargeCounter);
    chk("reference", 16'h1000, measuredFullReference);
    chk("flags", 16'h0600, flags);
  endtask : resetChk

  // settle, then watch two full bank periods
  task automatic show(input logic [4:0] exp);
    cyc(10);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(40);
    chk("segments", {11'h000, exp}, {11'h000, litMask});
    chk("bankMix", 16'h0000, {15'h0000, mixErr});
    if (exp == 5'h1F) chk("onCycles", 16'd24, onCount[15:0]);
  endtask : show

  function automatic logic [4:0] segs(input logic [15:0] c);
    segs = 5'h00;
    for (int k = 0; k < 5; k++) begin
      if (c != 16'h0000 && 32'(c) * 5 > 32'h1000 * k) segs[k] = 1'b1;
    end
  endfunction : segs

  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    bad_count++;
    print_verdict();
  end

  initial begin
    cyc(6);
    reset_n = 1'b1;
    cyc(1);
    resetChk();
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      compChargeIn = 16'($random(seed));
      scaledEnergyIn = 16'($random(seed));
      cyc(1);
      rd(8'h0D, d);
      chk("compHi", {8'h00, compChargeIn[15:8]}, {8'h00, d});
      rd(8'h0E, d);
      chk("compLo", {8'h00, compChargeIn[7:0]}, {8'h00, d});
      rd(8'h0F, d);
      chk("energyHi", {8'h00, scaledEnergyIn[15:8]}, {8'h00, d});
      rd(8'h10, d);
      chk("energyLo", {8'h00, scaledEnergyIn[7:0]}, {8'h00, d});
      rd(8'h39, d);
      chk("resetRead", 16'h0000, {8'h00, d});
      rd(8'h20 + 8'(i), d);
      chk("unmapped", 16'h0000, {8'h00, d});
    end
    $display("test registers done");
    chargeStep = 1'b1;
    cyc(5);
    chargeStep = 1'b0;
    dischargeStep = 1'b1;
    cyc(2);
    dischargeStep = 1'b0;
    programInputFive = 1'b1;
    cyc(4);
    selfDischargeStep = 1'b1;
    cyc(4);
    selfDischargeStep = 1'b0;
    cyc(2);
    chk("nominalHeld", 16'h0003, nominalChargeCounter);
    programInputFive = 1'b0;
    cyc(4);
    selfDischargeStep = 1'b1;
    cyc(1);
    selfDischargeStep = 1'b0;
    cyc(2);
    chk("nominalSelf", 16'h0002, nominalChargeCounter);
    validDischargeSet = 1'b1;
    batteryReplacedClear = 1'b1;
    fullRefUpdate = 1'b1;
    fullRefValue = 16'($random(seed));
    cyc(1);
    {validDischargeSet, batteryReplacedClear, fullRefUpdate} = 3'b000;
    cyc(1);
    chk("refLoad", fullRefValue, measuredFullReference);
    chk("flagsUpd", 16'h0100, flags);
    validChargeEvent = 1'b1;
    cyc(63);
    validChargeEvent = 1'b0;
    cyc(1);
    chk("flags63", 16'h013F, flags);
    validChargeEvent = 1'b1;
    cyc(1);
    validChargeEvent = 1'b0;
    cyc(1);
    chk("flags64", 16'h0540, flags);
    wr(8'h39, 8'h00);
    wr(8'h39, 8'h80);
    chk("pulses", 16'h0001, pulses[15:0]);
    resetChk();
    chargeStep = 1'b1;
    cyc(1);
    chargeStep = 1'b0;
    wr(8'h39, 8'h80);
    chk("noRearm", 16'h0001, nominalChargeCounter);
    $display("test soft reset done");
    cases = '{16'h0000, 16'h0333, 16'h0334, 16'h1000, {3'b000, 13'($random(seed))}};
    {displayPullUpSense, displayPullDownSense, validChargeDetect} = 3'b101;
    foreach (cases[i]) begin
      compChargeIn = cases[i];
      show(segs(cases[i]));
    end
    validChargeDetect = 1'b0;
    show(5'h00);
    {displayPullDownSense, validChargeDetect} = 2'b11;
    show(5'h00);
    {displayPullUpSense, displayPullDownSense, validChargeDetect} = 3'b000;
    compChargeIn = 16'h1000;
    show(5'h1F);
    cyc(150);
    show(5'h00);
    {displayPullUpSense, validChargeDetect, finalEmptyWarningFlag} = 3'b111;
    show(5'h00);
    finalEmptyWarningFlag = 1'b0;
    firstEmptyWarningFlag = 1'b1;
    cyc(10);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(200);
    chk("blink", 16'd24, seg1Count[15:0]);
    $display("test display done");
    print_verdict();
  end
endmodule : gld_core_tb

// File: gld_led_if.sv
// link between the gauge core and its led bank multiplexer
`timescale 1ns/1ps
interface gld_led_if;
  logic [4:0] pattern;
  logic       enable;
  logic       blink;
  logic [4:0] segOn_n;
  logic       commonOn;

  modport core (output pattern, enable, blink, input segOn_n, commonOn);
  modport mux  (input pattern, enable, blink, output segOn_n, commonOn);
endinterface : gld_led_if

// File: gld_led_model.sv
// led bank model: records which segments light and the bank timing
`timescale 1ns/1ps
module gld_led_model (
  // led pins
  input  wire logic       clock,
  input  wire logic [4:0] segments_n,
  input  wire logic       common,
  // observation control
  input  wire logic       clear,
  // observations
  output logic [4:0]      litMask,
  output int              onCount,
  output int              seg1Count,
  output logic            mixErr
);
  logic [4:0] lit;

  // a segment glows only while its sink is low and the common line drives
  assign lit = ~segments_n & {5{common}};

  //////////////////////////////////////////////////////////////////////////////
  // bank observation
  always_ff @(posedge clock) begin
    if (clear) begin
      litMask <= 5'h00;
      onCount <= 0;
      seg1Count <= 0;
      mixErr <= 1'b0;
    end else begin
      litMask <= litMask | lit;
      onCount <= onCount + int'(common);
      seg1Count <= seg1Count + int'(lit[0]);
      if ((lit & 5'h15) != 5'h00 && (lit & 5'h0A) != 5'h00) begin
        mixErr <= 1'b1;
      end
    end
  end
endmodule : gld_led_model

// File: gld_led_mux.sv
// two-bank led multiplexer with low-battery blink of the first segment
`timescale 1ns/1ps
`include "gld_cfg.svh"
module gld_led_mux #(
  parameter int unsigned PERIOD_CYC     = `GLD_CLK_HZ / `GLD_MUX_HZ,
  parameter int unsigned ON_CYC         = PERIOD_CYC * `GLD_MUX_DUTY_PCT / 100,
  parameter int unsigned BLINK_HALF_CYC = `GLD_CLK_HZ / (2 * `GLD_BLINK_HZ)
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // core side
  gld_led_if.mux   ledBus
);
  localparam int unsigned CW = $clog2(PERIOD_CYC + 1);
  localparam int unsigned BW = $clog2(BLINK_HALF_CYC + 1);
  localparam logic [CW-1:0] LAST_C   = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] ON_C     = CW'(ON_CYC);
  localparam logic [CW-1:0] HALF_C   = CW'(PERIOD_CYC / 2);
  localparam logic [CW-1:0] HALFON_C = CW'(PERIOD_CYC / 2 + ON_CYC);
  localparam logic [BW-1:0] BLAST_C  = BW'(BLINK_HALF_CYC - 1);

  logic [CW-1:0] muxCount_reg;
  logic [BW-1:0] blinkCount_reg;
  logic          blinkPhase_reg;
  logic          bankA;
  logic          bankB;
  logic [4:0]    segNext;

  //////////////////////////////////////////////////////////////////////////////
  // modulation period
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      muxCount_reg <= '0;
    end else if (muxCount_reg == LAST_C) begin
      muxCount_reg <= '0;
    end else begin
      muxCount_reg <= muxCount_reg + CW'(1);
    end
  end

  assign bankA = muxCount_reg < ON_C;
  assign bankB = (muxCount_reg >= HALF_C) && (muxCount_reg < HALFON_C);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      blinkCount_reg <= '0;
      blinkPhase_reg <= 1'b0;
    end else if (blinkCount_reg == BLAST_C) begin
      blinkCount_reg <= '0;
      blinkPhase_reg <= ~blinkPhase_reg;
    end else begin
      blinkCount_reg <= blinkCount_reg + BW'(1);
    end
  end

  // odd segments on bank a, even on bank b
  for (genvar i = 0; i < `GLD_SEG_COUNT; i++) begin : g_seg
    if (i == 0) begin : g_first
      assign segNext[i] = ledBus.enable && ledBus.pattern[i] && bankA
                          && !(ledBus.blink && !blinkPhase_reg);
    end else if (i % 2 == 0) begin : g_odd
      assign segNext[i] = ledBus.enable && ledBus.pattern[i] && bankA;
    end else begin : g_even
      assign segNext[i] = ledBus.enable && ledBus.pattern[i] && bankB;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ledBus.segOn_n  <= 5'h1F;
      ledBus.commonOn <= 1'b0;
    end else begin
      ledBus.segOn_n  <= ~segNext;
      ledBus.commonOn <= ledBus.enable && (bankA || bankB);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_banks_apart;
    @(posedge clock) disable iff (!reset_n)
    !(&{ledBus.segOn_n[0], ledBus.segOn_n[2], ledBus.segOn_n[4]})
      |-> (&{ledBus.segOn_n[1], ledBus.segOn_n[3]});
  endproperty
  a_banks_apart: assert property (p_banks_apart)
    else $error("both led banks lit together");

  property p_bank_window;
    @(posedge clock) disable iff (!reset_n)
    (muxCount_reg == ON_C) && ledBus.enable |=> ledBus.segOn_n[2] && ledBus.segOn_n[4];
  endproperty
  a_bank_window: assert property (p_bank_window)
    else $error("bank a lit past its duty window");

  property p_blink_dark;
    @(posedge clock) disable iff (!reset_n)
    ledBus.blink && !blinkPhase_reg |=> ledBus.segOn_n[0];
  endproperty
  a_blink_dark: assert property (p_blink_dark)
    else $error("segment one lit in dark blink phase");

endmodule : gld_led_mux

// File: gld_pkg.sv
// shared types of the gauge display block
package gld_pkg;

  // resolved level of the three-state display-control pin
  typedef enum logic [1:0] {
    DISPLAY_CONTROL_INPUT_HIGH  = 2'b00,
    DISPLAY_CONTROL_INPUT_LOW   = 2'b01,
    DISPLAY_CONTROL_INPUT_FLOAT = 2'b10
  } gld_display_control_input_mode_type;

  // display enable sequencer
  typedef enum logic [1:0] {
    ST_DARK   = 2'b00,
    ST_CHARGE = 2'b01,
    ST_TIMED  = 2'b10
  } gld_display_control_input_state_type;

endpackage : gld_pkg
